// file: design/wake_bit_time_recovery_regs.v
`timescale 1ns/1ps
`include "wake_cdr_consts.vh"

// Overview of operation
// - Read-only calibration high byte at 0x3a, zero after reset.
// - Read-only calibration low byte at 0x3b, zero after reset.
// - Filter select codes 00, 01, 10 give constants 8, 16, 32.
// - Code 11 adapts: 2-3 bits 32, 4-8 bits 16, 9-10 bits 8.
// - Control one bit 0 enables recovery.
// - Control one resets to 0x04; restart clears only enable.
// - Clock select 00..11 gives 80, 40, 20, 10 MHz recovery clock.
// - Upper limit register, reset 0xa8, clamps the recovered bit time.
// - Reserved control bits read zero and ignore writes.
// - Lower limit register, reset 0x98, clamps the recovered bit time.
module wake_bit_time_recovery_regs (
  input wire ref_clk_in, // 25 MHz clock
  input wire rst_in, // Power-on or soft reset, sync
  input wire restart_in, // Restart pulse
  input wire [6:0] reg_addr_in, // Register address
  input wire reg_wr_in, // Write strobe
  input wire reg_rd_in, // Read strobe
  input wire [7:0] reg_wdata_in, // Write data
  input wire osc_tick_in, // Fastest recovery tick
  input wire bus_rx_in, // Bus receive pin
  input wire [7:0] bit_time_setting_in, // Programmed bit time
  output wire [7:0] reg_rdata_out, // Read data
  output wire reg_hit_out, // Address in this bank
  output wire recovery_enable_out, // Recovery enabled
  output wire recovery_tick_out, // Selected recovery tick
  output wire [7:0] effective_bit_time_out // Bit time in use
);

  // ==========================================================
  // Control state
  reg enable_r;
  reg [1:0] filt_sel_r;
  reg [1:0] clk_sel_r;
  reg [7:0] upper_r;
  reg [7:0] lower_r;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;
  reg enable_d_r;

  // ==========================================================
  // Measurement state
  reg rx_meta_r;
  reg rx_sync_r;
  reg rx_prev_r;
  reg [2:0] div_cnt_r;
  reg [11:0] spacing_r;
  reg started_r;
  reg sample_valid_r;
  reg [11:0] sample_r;
  reg [2:0] div_mask;

  wire fall;
  wire rec_tick;
  wire load;
  wire [12:0] acc;
  wire [7:0] cal_high;
  wire [7:0] cal_low;

  // Full reset word, so single fields can be picked out at their width
  localparam [7:0] CTRL_ONE_INIT = `CTRL_ONE_RESET;

  // Address decode, shared by the write path and reg_hit_out
  function is_bank;
    input [6:0] addr;
    begin
      is_bank = (addr >= `CAL_HIGH_ADDR) && (addr <= `LOWER_LIMIT_ADDR);
    end
  endfunction

  assign reg_hit_out = is_bank(reg_addr_in);

  // ==========================================================
  // Register writes
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      enable_r <= CTRL_ONE_INIT[`ENABLE_BIT];
      filt_sel_r <= `FILT_SEL_RESET;
      clk_sel_r <= `CLK_SEL_RESET;
      upper_r <= `UPPER_LIMIT_RESET;
      lower_r <= `LOWER_LIMIT_RESET;
    end else if (restart_in) begin
      enable_r <= 1'b0;
    end else if (reg_wr_in && is_bank(reg_addr_in)) begin
      case (reg_addr_in)
        `CTRL_ONE_ADDR: begin
          enable_r <= reg_wdata_in[`ENABLE_BIT];
          filt_sel_r <= reg_wdata_in[`FILT_SEL_MSB:`FILT_SEL_LSB];
        end
        `CTRL_TWO_ADDR: begin
          clk_sel_r <= reg_wdata_in[`CLK_SEL_MSB:`CLK_SEL_LSB];
        end
        `UPPER_LIMIT_ADDR: begin
          upper_r <= reg_wdata_in;
        end
        `LOWER_LIMIT_ADDR: begin
          lower_r <= reg_wdata_in;
        end
        default: begin
          // Calibration bytes are read-only
          upper_r <= upper_r;
        end
      endcase
    end
  end

  // ==========================================================
  // Register reads, one cycle after the strobe
  always @* begin
    rdata_nxt = 8'h00;
    case (reg_addr_in)
      `CAL_HIGH_ADDR: rdata_nxt = cal_high;
      `CAL_LOW_ADDR: rdata_nxt = cal_low;
      `CTRL_ONE_ADDR: rdata_nxt = {4'h0, filt_sel_r, 1'b0, enable_r};
      `CTRL_TWO_ADDR: rdata_nxt = {6'h00, clk_sel_r};
      `UPPER_LIMIT_ADDR: rdata_nxt = upper_r;
      `LOWER_LIMIT_ADDR: rdata_nxt = lower_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

  // ==========================================================
  // Recovery clock divider: the tick stands for the 80 MHz rate
  always @* begin
    case (clk_sel_r)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      div_cnt_r <= 3'h0;
    end else if (osc_tick_in) begin
      div_cnt_r <= div_cnt_r + 3'h1;
    end
  end

  assign rec_tick = osc_tick_in && ((div_cnt_r & div_mask) == 3'h0);
  assign recovery_tick_out = rec_tick;

  // ==========================================================
  // Receive pin synchroniser and falling edge
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_meta_r <= bus_rx_in;
      rx_sync_r <= rx_meta_r;
      rx_prev_r <= rx_sync_r;
    end
  end

  assign fall = rx_prev_r && !rx_sync_r;

  // ==========================================================
  // Falling edge spacing counter
  // Saturates so that a long idle gap never yields a false sample
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      spacing_r <= 12'h000;
      started_r <= 1'b0;
      sample_valid_r <= 1'b0;
      sample_r <= 12'h000;
    end else begin
      sample_valid_r <= 1'b0;
      if (!enable_r) begin
        started_r <= 1'b0;
        spacing_r <= 12'h000;
      end else if (fall) begin
        started_r <= 1'b1;
        spacing_r <= 12'h000;
        // measured spacing
        // The tick in the fall cycle closes the interval
        if (started_r && spacing_r != `SPACING_MAX) begin
          sample_valid_r <= 1'b1;
          sample_r <= spacing_r + {11'h000, rec_tick};
        end
      end else if (rec_tick && spacing_r != `SPACING_MAX) begin
        spacing_r <= spacing_r + 12'h001;
      end
    end
  end

  // ==========================================================
  // Enable edge seeds the filter from the programmed bit time
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      enable_d_r <= 1'b0;
    end else begin
      enable_d_r <= enable_r;
    end
  end

  assign load = enable_r && !enable_d_r;
  assign recovery_enable_out = enable_r;

  cdr_bit_time_filter u_filter (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .enable_in(enable_r),
    .load_in(load),
    .sample_valid_in(sample_valid_r),
    .spacing_in(sample_r),
    .filt_sel_in(filt_sel_r),
    .setting_in(bit_time_setting_in),
    .upper_in(upper_r),
    .lower_in(lower_r),
    .bit_time_out(effective_bit_time_out),
    .acc_out(acc)
  );

  // Calibration word: integer bit time, then fraction left aligned
  assign cal_high = acc[12:5];
  assign cal_low = {acc[4:0], 3'h0};

endmodule // wake_bit_time_recovery_regs

// file: design/wake_cdr_consts.vh
`ifndef WAKE_CDR_CONSTS_VH
`define WAKE_CDR_CONSTS_VH

// ==========================================================
// Register addresses on the 7-bit serial control port
`define CAL_HIGH_ADDR 7'h3a
`define CAL_LOW_ADDR 7'h3b
`define CTRL_ONE_ADDR 7'h3c
`define CTRL_TWO_ADDR 7'h3d
`define UPPER_LIMIT_ADDR 7'h3e
`define LOWER_LIMIT_ADDR 7'h3f

// ==========================================================
// Field positions
`define ENABLE_BIT 0
`define FILT_SEL_LSB 2
`define FILT_SEL_MSB 3
`define CLK_SEL_LSB 0
`define CLK_SEL_MSB 1

// ==========================================================
// Reset values
`define CAL_RESET 8'h00
`define CTRL_ONE_RESET 8'h04
`define CTRL_TWO_RESET 8'h00
`define UPPER_LIMIT_RESET 8'ha8
`define LOWER_LIMIT_RESET 8'h98
`define FILT_SEL_RESET 2'h1
`define CLK_SEL_RESET 2'h0

// ==========================================================
// Filter codes and their shift counts (constant 8, 16, 32)
`define FILT_CODE_8 2'h0
`define FILT_CODE_16 2'h1
`define FILT_CODE_32 2'h2
`define FILT_CODE_ADAPT 2'h3
`define SHIFT_8 3'h3
`define SHIFT_16 3'h4
`define SHIFT_32 3'h5

// ==========================================================
// Edge spacing in bits accepted by the filter
`define MIN_BITS 12'h0002
`define MAX_BITS 12'h000a
`define ADAPT_32_MAX 12'h0003
`define ADAPT_16_MAX 12'h0008
`define SPACING_MAX 12'h07ff
`define FRAC_BITS 5

`endif

// file: design/cdr_bit_time_filter.v
`timescale 1ns/1ps
`include "wake_cdr_consts.vh"

module cdr_bit_time_filter (
  input wire ref_clk_in, // 25 MHz clock
  input wire rst_in, // Sync reset, active high
  input wire enable_in, // Recovery enabled
  input wire load_in, // Enable just rose
  input wire sample_valid_in, // Falling edge spacing ready
  input wire [11:0] spacing_in, // Ticks between falling edges
  input wire [1:0] filt_sel_in, // Filter constant select
  input wire [7:0] setting_in, // Programmed bit time
  input wire [7:0] upper_in, // Upper bound
  input wire [7:0] lower_in, // Lower bound
  output wire [7:0] bit_time_out, // Effective bit time
  output wire [12:0] acc_out // Filter state, 8.5 fixed point
);

  reg [12:0] acc_r;
  reg [12:0] acc_nxt;
  reg [11:0] nbits;
  reg [11:0] sample;
  reg [7:0] sample8;
  reg [2:0] shift;
  reg signed [13:0] diff;
  reg signed [13:0] step;
  reg [13:0] sum;
  wire [7:0] bt_now;
  wire [12:0] up_fx;
  wire [12:0] lo_fx;

  // Restoring divider; zero divisor yields all ones
  function [11:0] div12;
    input [11:0] num;
    input [7:0] den;
    reg [12:0] rem;
    integer i;
    begin
      rem = 13'h0000;
      div12 = 12'h000;
      for (i = 11; i >= 0; i = i - 1) begin
        rem = {rem[11:0], num[i]};
        if (rem >= {5'h00, den}) begin
          rem = rem - {5'h00, den};
          div12[i] = 1'b1;
        end
      end
    end
  endfunction

  assign bt_now = acc_r[12:`FRAC_BITS];
  assign up_fx = {upper_in, 5'h00};
  assign lo_fx = {lower_in, 5'h00};

  // ==========================================================
  // Sample evaluation
  always @* begin
    nbits = div12(spacing_in + {5'h00, bt_now[7:1]}, bt_now);
    sample = div12(spacing_in, {4'h0, nbits[3:0]});
    sample8 = (sample > 12'h00ff) ? 8'hff : sample[7:0];
    case (filt_sel_in)
      `FILT_CODE_8: shift = `SHIFT_8;
      `FILT_CODE_16: shift = `SHIFT_16;
      `FILT_CODE_32: shift = `SHIFT_32;
      default: begin
        if (nbits <= `ADAPT_32_MAX) begin
          shift = `SHIFT_32;
        end else if (nbits <= `ADAPT_16_MAX) begin
          shift = `SHIFT_16;
        end else begin
          shift = `SHIFT_8;
        end
      end
    endcase
    diff = $signed({1'b0, sample8, 5'h00}) - $signed({1'b0, acc_r});
    step = diff >>> shift;
    sum = $unsigned($signed({1'b0, acc_r}) + step);
    acc_nxt = sum[12:0];
    if (sum[13] == 1'b0 && sum[12:0] > up_fx) begin
      acc_nxt = up_fx;
    end
    if (sum[13] == 1'b1 || sum[12:0] < lo_fx) begin
      acc_nxt = lo_fx;
    end
  end

  // ==========================================================
  // Filter state; out-of-range spacings are ignored
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      acc_r <= 13'h0000;
    end else if (load_in) begin
      acc_r <= {setting_in, 5'h00};
    end else if (enable_in && sample_valid_in && bt_now != 8'h00 &&
                 nbits >= `MIN_BITS && nbits <= `MAX_BITS) begin
      acc_r <= acc_nxt;
    end
  end

  assign bit_time_out = enable_in ? bt_now : setting_in;
  assign acc_out = acc_r;

endmodule // cdr_bit_time_filter

// file: dv/wake_cdr_checker.sv
`timescale 1ns/1ps
module wake_cdr_checker (
  input wire ref_clk_in, // clock
  input wire rst_in, // reset
  input wire restart_in, // restart
  input wire [6:0] reg_addr_in, // address
  input wire reg_wr_in, // write
  input wire reg_rd_in, // read
  input wire [7:0] reg_wdata_in, // write data
  input wire osc_tick_in, // fast tick
  input wire bus_rx_in, // rx pin
  input wire [7:0] bit_time_setting_in, // setting
  input wire [7:0] reg_rdata_out, // read data
  input wire reg_hit_out, // decode
  input wire recovery_enable_out, // enable
  input wire recovery_tick_out, // divided tick
  input wire [7:0] effective_bit_time_out // bit time
);
  // ==========================================
  // Shadow of clock select
  reg [1:0] sel_r;
  always @(posedge ref_clk_in) begin
    if (rst_in)
      sel_r <= 2'h0;
    else if (reg_wr_in && !restart_in && reg_addr_in == 7'h3d)
      sel_r <= reg_wdata_in[1:0];
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // ==========================================
  // Assertions
  a_ctrl1_reserved: assert property (reg_rd_in && reg_addr_in == 7'h3c |=>
    (reg_rdata_out & 8'hf2) == 8'h00) else $error("control one reserved bits set");
  a_ctrl2_reserved: assert property (reg_rd_in && reg_addr_in == 7'h3d |=>
    (reg_rdata_out & 8'hfc) == 8'h00) else $error("control two reserved bits set");
  a_restart_clears: assert property (restart_in |=> !recovery_enable_out)
    else $error("enable survived restart");
  a_enable_follows: assert property (reg_wr_in && !restart_in && reg_addr_in == 7'h3c |=>
    recovery_enable_out == $past(reg_wdata_in[0])) else $error("enable not written");
  a_disabled_bypass: assert property (!recovery_enable_out |->
    effective_bit_time_out == bit_time_setting_in) else $error("bypass wrong");
  a_tick_gated: assert property (recovery_tick_out |-> osc_tick_in)
    else $error("tick without oscillator tick");
  a_tick_direct: assert property (sel_r == 2'h0 |-> recovery_tick_out == osc_tick_in)
    else $error("fastest clock not passed through");
  a_hit_range: assert property (reg_hit_out == (reg_addr_in >= 7'h3a && reg_addr_in <= 7'h3f))
    else $error("address decode wrong");
  a_unmapped_zero: assert property (reg_rd_in && !reg_hit_out |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  cover property (restart_in && recovery_enable_out);
  cover property (recovery_enable_out && $changed(effective_bit_time_out));
  cover property (reg_rd_in && !reg_hit_out);
endmodule // wake_cdr_checker
bind wake_bit_time_recovery_regs wake_cdr_checker chk (.ref_clk_in, .rst_in, .restart_in,
  .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .osc_tick_in, .bus_rx_in,
  .bit_time_setting_in, .reg_rdata_out, .reg_hit_out, .recovery_enable_out,
  .recovery_tick_out, .effective_bit_time_out);

// file: dv/rx_edge_source.sv
`timescale 1ns/1ps
module rx_edge_source (
  input wire ref_clk_in, // clock
  input wire go_in, // start two falls
  input wire [11:0] spacing_in, // cycles between falls
  output reg bus_rx_out, // idle high, pulled up
  output reg busy_out // falls in progress
);
  initial begin
    bus_rx_out = 1'b1;
    busy_out = 1'b0;
  end
  always begin
    @(posedge ref_clk_in);
    if (go_in) begin
      busy_out = 1'b1;
      @(negedge ref_clk_in);
      bus_rx_out = 1'b0;
      repeat (2) @(negedge ref_clk_in);
      bus_rx_out = 1'b1;
      repeat (spacing_in - 2) @(negedge ref_clk_in);
      bus_rx_out = 1'b0;
      repeat (2) @(negedge ref_clk_in);
      bus_rx_out = 1'b1;
      busy_out = 1'b0;
    end
  end
endmodule // rx_edge_source

// file: dv/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb;
  reg ref_clk_in = 0, rst_in = 1, restart_in = 0, reg_wr_in = 0, reg_rd_in = 0;
  reg osc_tick_in = 1, go = 0;
  reg [6:0] reg_addr_in = 7'h00;
  reg [7:0] reg_wdata_in = 8'h00, bit_time_setting_in = 8'ha0, v;
  reg [11:0] spacing = 12'h000;
  wire [7:0] reg_rdata_out, effective_bit_time_out;
  wire bus_rx, busy, reg_hit_out, recovery_enable_out, recovery_tick_out;
  int fails = 0, check_count = 0, n, i;
  always #20 ref_clk_in = ~ref_clk_in;
  wake_bit_time_recovery_regs uut (.ref_clk_in, .rst_in, .restart_in, .reg_addr_in,
    .reg_wr_in, .reg_rd_in, .reg_wdata_in, .osc_tick_in, .bus_rx_in(bus_rx),
    .bit_time_setting_in, .reg_rdata_out, .reg_hit_out, .recovery_enable_out,
    .recovery_tick_out, .effective_bit_time_out);
  rx_edge_source src (.ref_clk_in, .go_in(go), .spacing_in(spacing), .bus_rx_out(bus_rx),
    .busy_out(busy));
  task complete_run;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wr(input [6:0] a, input [7:0] d);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1;
    @(negedge ref_clk_in);
    reg_wr_in = 0;
  endtask
  task rd(input [6:0] a, input [7:0] e);
    @(negedge ref_clk_in);
    reg_addr_in = a;
    reg_rd_in = 1;
    @(negedge ref_clk_in);
    reg_rd_in = 0;
    `CHK("read data", e, reg_rdata_out)
  endtask
  // Filter after one sample from a fresh load
  function automatic int model(input int sh, per, lo, hi);
    int a;
    a = bit_time_setting_in * 32;
    a = (a + ((per * 32 - a) >>> sh)) >> 5;
    if (a < lo) a = lo;
    if (a > hi) a = hi;
    return a;
  endfunction
  task rec(input [1:0] code, input [11:0] s, input int sh, per, lo, hi);
    wr(7'h3e, hi[7:0]);
    wr(7'h3f, lo[7:0]);
    wr(7'h3c, {4'h0, code, 2'b01});
    spacing = s;
    @(negedge ref_clk_in);
    go = 1;
    @(negedge ref_clk_in);
    go = 0;
    n = 0;
    while (busy && n < 2000) begin
      @(negedge ref_clk_in);
      n++;
    end
    repeat (8) @(negedge ref_clk_in);
    `CHK("bit time", model(sh, per, lo, hi), effective_bit_time_out)
    wr(7'h3c, 8'h00);
    `CHK("bypass", bit_time_setting_in, effective_bit_time_out)
  endtask
  initial begin
    v = 8'($urandom(32'h0000_c4a2));
    repeat (10) @(negedge ref_clk_in);
    rst_in = 0;
    rd(7'h3a, 8'h00);
    rd(7'h3b, 8'h00);
    rd(7'h3c, 8'h04);
    rd(7'h3d, 8'h00);
    rd(7'h3e, 8'ha8);
    rd(7'h3f, 8'h98);
    rd(7'h40, 8'h00);
    for (i = 0; i < 4; i++) begin
      v = 8'($urandom);
      wr(7'h3a, v);
      wr(7'h3b, v);
      rd(7'h3a, 8'h00);
      rd(7'h3b, 8'h00);
      wr(7'h3c, v & 8'hfe);
      rd(7'h3c, v & 8'h0c);
      wr(7'h3d, v);
      rd(7'h3d, v & 8'h03);
    end
    wr(7'h3c, 8'h0d);
    `CHK("enable", 1'b1, recovery_enable_out)
    @(negedge ref_clk_in);
    restart_in = 1;
    @(negedge ref_clk_in);
    restart_in = 0;
    rd(7'h3c, 8'h0c);
    for (i = 0; i < 4; i++) begin
      wr(7'h3d, i[7:0]);
      n = 0;
      // Oscillator tick every other cycle, so gating is exercised too
      repeat (64) begin
        @(negedge ref_clk_in);
        n += recovery_tick_out;
        osc_tick_in = ~osc_tick_in;
      end
      `CHK("ticks", 32 >> i, n)
    end
    // Fastest clock with the suggested 500k values
    wr(7'h3d, 8'h00);
    rec(2'h0, 12'h17c, 3, 190, 152, 168);
    rec(2'h1, 12'h17c, 4, 190, 152, 168);
    rec(2'h2, 12'h17c, 5, 190, 152, 168);
    rec(2'h3, 12'h17c, 5, 190, 152, 168);
    rec(2'h3, 12'h230, 4, 140, 152, 168);
    rec(2'h3, 12'h550, 3, 151, 152, 168);
    rec(2'h0, 12'h17c, 3, 190, 152, 162);
    rec(2'h0, 12'h118, 3, 140, 158, 168);
    complete_run;
  end
  initial begin
    #600000;
    fails++;
    complete_run;
  end
endmodule // tb
